// [port_a_pin_function_mux.sv]
// Port A pin function multiplexer with its select registers
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module port_a_pin_function_mux
	import port_a_mux_pkg::*;
(
	input wire logic clk, // System clock, 50 MHz
	input wire logic reset, // Synchronous, active high
	input wire logic [7:0] regAddr, // Register byte address
	input wire logic [31:0] regWrData, // Register write data
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	output logic [31:0] regRdData, // Read data, cycle after strobe
	input wire logic [NUM_PINS-1:0] pinIn, // Pad input levels
	output logic [NUM_PINS-1:0] pinOut, // Pad output levels
	output logic [NUM_PINS-1:0] pinOe, // Pad output enables
	input wire logic [NUM_PINS-1:0] gpioOut, // General I/O drive
	input wire logic [NUM_PINS-1:0] gpioOe, // General I/O enables
	output logic [NUM_PINS-1:0] gpioIn, // Synced pin levels
	input wire logic [3:0] pwmOutA, // PWM units 1-4, output A
	input wire logic [3:0] pwmOutB, // PWM units 1-4, output B
	input wire logic comparator1Out, // Comparator 1 result
	input wire logic comparator2Out, // Comparator 2 result
	input wire logic pwmSyncOutput, // PWM sync output
	input wire logic capture1Out, // Capture 1 drive
	input wire logic capture1Oe, // Capture 1 enable
	input wire logic spiClockOut, // SPI clock drive
	input wire logic spiClockOe, // SPI clock enable
	input wire logic spiSlaveEnableOut, // SPI slave enable drive
	input wire logic spiSlaveEnableOe, // SPI slave enable enable
	input wire logic spiDataToSlaveOut, // SPI master-out drive
	input wire logic spiDataToSlaveOe, // SPI master-out enable
	input wire logic spiDataFromSlaveOut, // SPI slave-out drive
	input wire logic spiDataFromSlaveOe, // SPI slave-out enable
	input wire logic serialTransmit, // Serial transmit line
	input wire logic i2cDataPullLow, // I2C data pulls low
	input wire logic i2cClockPullLow, // I2C clock pulls low
	input wire logic clockOutputPin, // Clock output source
	output logic [NUM_INPUTS-1:0] periphInput // Routed inputs
);

	// ==========================================================
	// Pin input synchroniser
	pin_sync_if #(.WIDTH(NUM_PINS)) syncBus ();
	logic [NUM_PINS-1:0] pinLevel; // Filtered pad levels

	assign syncBus.raw = pinIn;
	assign pinLevel = syncBus.level;

	pin_sync #(
		.WIDTH(NUM_PINS)
	) pinSyncInst (
		.clk(clk),
		.reset(reset),
		.port(syncBus)
	);

	// ==========================================================
	// Select registers
	logic [31:0] selLow_reg; // Pins 0-15, two bits each
	logic [31:0] selHigh_reg; // Pins 16-31, two bits each
	logic [63:0] selAll; // Both registers as one field array

	assign selAll = {selHigh_reg, selLow_reg};

	// Software writes; reserved fields stay zero
	always_ff @(posedge clk) begin
		if (reset) begin
			selLow_reg <= SEL_LOW_RESET;
			selHigh_reg <= SEL_HIGH_RESET;
		end else if (regWrite) begin
			if (regAddr == SEL_LOW_ADDR) begin
				selLow_reg <= regWrData & SEL_LOW_WMASK;
			end else if (regAddr == SEL_HIGH_ADDR) begin
				selHigh_reg <= regWrData & SEL_HIGH_WMASK;
			end
		end
	end

	// ==========================================================
	// Register read port
	logic [31:0] rdData_reg; // Read data, valid one cycle
	logic [31:0] rdData_next; // Decoded read value
	logic [NUM_INPUTS-1:0] defaulted_reg; // Inputs on default

	// Address decode; unmapped addresses read zero
	always_comb begin
		rdData_next = READ_IDLE;
		unique case (regAddr)
			SEL_LOW_ADDR: rdData_next = selLow_reg;
			SEL_HIGH_ADDR: rdData_next = selHigh_reg;
			PIN_LEVEL_ADDR: rdData_next = pinLevel;
			DEFAULTED_ADDR: rdData_next = 32'(defaulted_reg);
			default: rdData_next = READ_IDLE;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdData_reg <= READ_IDLE;
		end else if (regRead) begin
			rdData_reg <= rdData_next;
		end else begin
			rdData_reg <= READ_IDLE;
		end
	end

	assign regRdData = rdData_reg;

	// ==========================================================
	// Helpers
	// Field of one pin from the joined select array
	function automatic logic [1:0] selOf(input logic [63:0] sels,
		input int pin);
		selOf = sels[2*pin +: 2];
	endfunction

	// Default unless exactly one source is selected, then follow it
	function automatic logic [1:0] pickInput(input logic [2:0] hits,
		input logic [2:0] levels, input logic dflt);
		logic single;
		single = (hits != 3'h0) && ((hits & (hits - 3'h1)) == 3'h0);
		if (single) begin
			pickInput = {1'b0, |(hits & levels)};
		end else begin
			pickInput = {1'b1, dflt};
		end
	endfunction

	// ==========================================================
	// Pin output mux
	logic [NUM_PINS-1:0] pinOut_next; // Pad drive before the flop
	logic [NUM_PINS-1:0] pinOe_next; // Pad enable before the flop

	// Each pin follows its own field, so a peripheral output may
	// appear on several pins at once.
	// Reserved codes leave the pin undriven; software must not use
	// them, and this is the safest reading of an undefined state.
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (selOf(selAll, i) == SEL_GPIO) begin
				pinOut_next[i] = gpioOut[i];
				pinOe_next[i] = gpioOe[i];
			end else begin
				pinOut_next[i] = 1'b0;
				pinOe_next[i] = 1'b0;
			end
		end
		// PWM A outputs on pins 0, 2, 4
		if (selOf(selAll, PIN_0) == SEL_PERIPH1) begin
			pinOut_next[PIN_0] = pwmOutA[0];
			pinOe_next[PIN_0] = 1'b1;
		end
		if (selOf(selAll, PIN_2) == SEL_PERIPH1) begin
			pinOut_next[PIN_2] = pwmOutA[1];
			pinOe_next[PIN_2] = 1'b1;
		end
		if (selOf(selAll, PIN_4) == SEL_PERIPH1) begin
			pinOut_next[PIN_4] = pwmOutA[2];
			pinOe_next[PIN_4] = 1'b1;
		end
		// PWM B and comparator or capture on pins 1, 3, 5
		unique case (selOf(selAll, PIN_1))
			SEL_PERIPH1: begin
				pinOut_next[PIN_1] = pwmOutB[0];
				pinOe_next[PIN_1] = 1'b1;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_1] = comparator1Out;
				pinOe_next[PIN_1] = 1'b1;
			end
			default: ;
		endcase
		unique case (selOf(selAll, PIN_3))
			SEL_PERIPH1: begin
				pinOut_next[PIN_3] = pwmOutB[1];
				pinOe_next[PIN_3] = 1'b1;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_3] = comparator2Out;
				pinOe_next[PIN_3] = 1'b1;
			end
			default: ;
		endcase
		unique case (selOf(selAll, PIN_5))
			SEL_PERIPH1: begin
				pinOut_next[PIN_5] = pwmOutB[2];
				pinOe_next[PIN_5] = 1'b1;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_5] = capture1Out;
				pinOe_next[PIN_5] = capture1Oe;
			end
			default: ;
		endcase
		// Pin 6: PWM4 A, sync input (undriven), sync output
		unique case (selOf(selAll, PIN_6))
			SEL_PERIPH1: begin
				pinOut_next[PIN_6] = pwmOutA[3];
				pinOe_next[PIN_6] = 1'b1;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_6] = pwmSyncOutput;
				pinOe_next[PIN_6] = 1'b1;
			end
			default: ;
		endcase
		// Pin 7: PWM4 B; serial receive leaves it undriven
		if (selOf(selAll, PIN_7) == SEL_PERIPH1) begin
			pinOut_next[PIN_7] = pwmOutB[3];
			pinOe_next[PIN_7] = 1'b1;
		end
		// Pin 12: serial transmit; trip zone 1 is input only
		if (selOf(selAll, PIN_12) == SEL_PERIPH2) begin
			pinOut_next[PIN_12] = serialTransmit;
			pinOe_next[PIN_12] = 1'b1;
		end
		// Pins 16, 17: SPI data lines, drive set by the SPI
		if (selOf(selAll, PIN_16) == SEL_PERIPH1) begin
			pinOut_next[PIN_16] = spiDataToSlaveOut;
			pinOe_next[PIN_16] = spiDataToSlaveOe;
		end
		if (selOf(selAll, PIN_17) == SEL_PERIPH1) begin
			pinOut_next[PIN_17] = spiDataFromSlaveOut;
			pinOe_next[PIN_17] = spiDataFromSlaveOe;
		end
		// Pin 18: SPI clock, serial transmit, clock output
		unique case (selOf(selAll, PIN_18))
			SEL_PERIPH1: begin
				pinOut_next[PIN_18] = spiClockOut;
				pinOe_next[PIN_18] = spiClockOe;
			end
			SEL_PERIPH2: begin
				pinOut_next[PIN_18] = serialTransmit;
				pinOe_next[PIN_18] = 1'b1;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_18] = clockOutputPin;
				pinOe_next[PIN_18] = 1'b1;
			end
			default: ;
		endcase
		// Pin 19: SPI slave enable, serial receive, capture 1
		unique case (selOf(selAll, PIN_19))
			SEL_PERIPH1: begin
				pinOut_next[PIN_19] = spiSlaveEnableOut;
				pinOe_next[PIN_19] = spiSlaveEnableOe;
			end
			SEL_PERIPH3: begin
				pinOut_next[PIN_19] = capture1Out;
				pinOe_next[PIN_19] = capture1Oe;
			end
			default: ;
		endcase
		// Pin 28: I2C data is open drain, only ever pulls low
		if (selOf(selAll, PIN_28) == SEL_PERIPH2) begin
			pinOut_next[PIN_28] = 1'b0;
			pinOe_next[PIN_28] = i2cDataPullLow;
		end
		// Pin 29: serial transmit, I2C clock open drain
		unique case (selOf(selAll, PIN_29))
			SEL_PERIPH1: begin
				pinOut_next[PIN_29] = serialTransmit;
				pinOe_next[PIN_29] = 1'b1;
			end
			SEL_PERIPH2: begin
				pinOut_next[PIN_29] = 1'b0;
				pinOe_next[PIN_29] = i2cClockPullLow;
			end
			default: ;
		endcase
	end

	// ==========================================================
	// Peripheral input routing
	logic [1:0] route [NUM_INPUTS]; // {defaulted, level} per input

	// Candidate pins for each input, checked against their fields
	always_comb begin
		route[IN_TRIP1] = pickInput(
			{2'h0, selOf(selAll, PIN_12) == SEL_PERIPH1},
			{2'h0, pinLevel[PIN_12]}, INPUT_DEFAULTS[IN_TRIP1]);
		route[IN_TRIP2] = pickInput(
			{1'b0, selOf(selAll, PIN_16) == SEL_PERIPH3,
			selOf(selAll, PIN_28) == SEL_PERIPH3},
			{1'b0, pinLevel[PIN_16], pinLevel[PIN_28]},
			INPUT_DEFAULTS[IN_TRIP2]);
		route[IN_TRIP3] = pickInput(
			{1'b0, selOf(selAll, PIN_17) == SEL_PERIPH3,
			selOf(selAll, PIN_29) == SEL_PERIPH3},
			{1'b0, pinLevel[PIN_17], pinLevel[PIN_29]},
			INPUT_DEFAULTS[IN_TRIP3]);
		route[IN_SYNC] = pickInput(
			{2'h0, selOf(selAll, PIN_6) == SEL_PERIPH2},
			{2'h0, pinLevel[PIN_6]}, INPUT_DEFAULTS[IN_SYNC]);
		route[IN_CAPTURE] = pickInput(
			{1'b0, selOf(selAll, PIN_5) == SEL_PERIPH3,
			selOf(selAll, PIN_19) == SEL_PERIPH3},
			{1'b0, pinLevel[PIN_5], pinLevel[PIN_19]},
			INPUT_DEFAULTS[IN_CAPTURE]);
		route[IN_SPI_CLK] = pickInput(
			{2'h0, selOf(selAll, PIN_18) == SEL_PERIPH1},
			{2'h0, pinLevel[PIN_18]}, INPUT_DEFAULTS[IN_SPI_CLK]);
		route[IN_SPI_STE] = pickInput(
			{2'h0, selOf(selAll, PIN_19) == SEL_PERIPH1},
			{2'h0, pinLevel[PIN_19]}, INPUT_DEFAULTS[IN_SPI_STE]);
		route[IN_SPI_SIMO] = pickInput(
			{2'h0, selOf(selAll, PIN_16) == SEL_PERIPH1},
			{2'h0, pinLevel[PIN_16]}, INPUT_DEFAULTS[IN_SPI_SIMO]);
		route[IN_SPI_SOMI] = pickInput(
			{2'h0, selOf(selAll, PIN_17) == SEL_PERIPH1},
			{2'h0, pinLevel[PIN_17]}, INPUT_DEFAULTS[IN_SPI_SOMI]);
		route[IN_SERIAL_RX] = pickInput(
			{selOf(selAll, PIN_7) == SEL_PERIPH2,
			selOf(selAll, PIN_19) == SEL_PERIPH2,
			selOf(selAll, PIN_28) == SEL_PERIPH1},
			{pinLevel[PIN_7], pinLevel[PIN_19], pinLevel[PIN_28]},
			INPUT_DEFAULTS[IN_SERIAL_RX]);
		route[IN_I2C_DATA] = pickInput(
			{2'h0, selOf(selAll, PIN_28) == SEL_PERIPH2},
			{2'h0, pinLevel[PIN_28]}, INPUT_DEFAULTS[IN_I2C_DATA]);
		route[IN_I2C_CLOCK] = pickInput(
			{2'h0, selOf(selAll, PIN_29) == SEL_PERIPH2},
			{2'h0, pinLevel[PIN_29]}, INPUT_DEFAULTS[IN_I2C_CLOCK]);
	end

	// ==========================================================
	// Output registers
	logic [NUM_PINS-1:0] pinOut_reg; // Registered pad drive
	logic [NUM_PINS-1:0] pinOe_reg; // Registered pad enable
	logic [NUM_INPUTS-1:0] periphInput_reg; // Registered inputs

	// Pads: reset hands every pin to general I/O, undriven
	always_ff @(posedge clk) begin
		if (reset) begin
			pinOut_reg <= '0;
			pinOe_reg <= '0;
		end else begin
			pinOut_reg <= pinOut_next;
			pinOe_reg <= pinOe_next;
		end
	end

	// Peripheral inputs; during reset they rest at their defaults
	always_ff @(posedge clk) begin
		if (reset) begin
			periphInput_reg <= INPUT_RESET;
			defaulted_reg <= '1;
		end else begin
			for (int k = 0; k < NUM_INPUTS; k++) begin
				periphInput_reg[k] <= route[k][0];
				defaulted_reg[k] <= route[k][1];
			end
		end
	end

	assign pinOut = pinOut_reg;
	assign pinOe = pinOe_reg;
	assign periphInput = periphInput_reg;
	// General I/O always sees the pad, whatever the function
	assign gpioIn = pinLevel;

endmodule

// [port_a_mux_pkg.sv]
// Constants shared by the port A pin function multiplexer
package port_a_mux_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_PINS = 32; // Port A pin count
	localparam int NUM_INPUTS = 12; // Routed peripheral inputs
	localparam int SYNC_STAGES = 3; // Synchroniser stages on each pin input

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] SEL_LOW_ADDR = 8'h00; // Select, pins 0-15
	localparam logic [7:0] SEL_HIGH_ADDR = 8'h04; // Select, pins 16-31
	localparam logic [7:0] PIN_LEVEL_ADDR = 8'h08; // Synced pin levels
	localparam logic [7:0] DEFAULTED_ADDR = 8'h0c; // Inputs on default

	// ==========================================================
	// Reset values and writable bits (reserved fields read zero)
	localparam logic [31:0] SEL_LOW_RESET = 32'h0000_0000;
	localparam logic [31:0] SEL_HIGH_RESET = 32'h0000_0000;
	localparam logic [31:0] SEL_LOW_WMASK = 32'h0300_ffff;
	localparam logic [31:0] SEL_HIGH_WMASK = 32'h0f00_00ff;
	localparam logic [31:0] READ_IDLE = 32'h0000_0000;

	// ==========================================================
	// Select field codes
	localparam logic [1:0] SEL_GPIO = 2'h0; // General I/O
	localparam logic [1:0] SEL_PERIPH1 = 2'h1; // Peripheral choice 1
	localparam logic [1:0] SEL_PERIPH2 = 2'h2; // Peripheral choice 2
	localparam logic [1:0] SEL_PERIPH3 = 2'h3; // Peripheral choice 3

	// ==========================================================
	// Pins that carry peripheral functions
	localparam int PIN_0 = 0;
	localparam int PIN_1 = 1;
	localparam int PIN_2 = 2;
	localparam int PIN_3 = 3;
	localparam int PIN_4 = 4;
	localparam int PIN_5 = 5;
	localparam int PIN_6 = 6;
	localparam int PIN_7 = 7;
	localparam int PIN_12 = 12;
	localparam int PIN_16 = 16;
	localparam int PIN_17 = 17;
	localparam int PIN_18 = 18;
	localparam int PIN_19 = 19;
	localparam int PIN_28 = 28;
	localparam int PIN_29 = 29;

	// ==========================================================
	// Peripheral input positions in periphInput and DEFAULTED
	localparam int IN_TRIP1 = 0;
	localparam int IN_TRIP2 = 1;
	localparam int IN_TRIP3 = 2;
	localparam int IN_SYNC = 3;
	localparam int IN_CAPTURE = 4;
	localparam int IN_SPI_CLK = 5;
	localparam int IN_SPI_STE = 6;
	localparam int IN_SPI_SIMO = 7;
	localparam int IN_SPI_SOMI = 8;
	localparam int IN_SERIAL_RX = 9;
	localparam int IN_I2C_DATA = 10;
	localparam int IN_I2C_CLOCK = 11;

	// Fixed levels when zero or several pins feed an input
	localparam logic [NUM_INPUTS-1:0] INPUT_DEFAULTS = 12'hfb7;
	localparam logic [NUM_INPUTS-1:0] INPUT_RESET = 12'hfb7;

endpackage

// [pin_sync_if.sv]
// Carrier between the mux and its pin input synchroniser
`timescale 1ns/1ps
interface pin_sync_if #(parameter int WIDTH = 32);
	logic [WIDTH-1:0] raw; // Pin levels straight from the pads
	logic [WIDTH-1:0] level; // Levels after synchronising

	modport sync (input raw, output level);
	modport user (output raw, input level);
endinterface

// [pin_sync.sv]
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
	import port_a_mux_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic clk, // System clock
	input wire logic reset, // Synchronous, active high
	pin_sync_if.sync port // Raw in, filtered level out
);

	// ==========================================================
	// Synchroniser chain
	logic [WIDTH-1:0] stage1_reg; // Metastable stage, read by stage 2 only
	logic [WIDTH-1:0] stage2_reg; // Second stage
	logic [WIDTH-1:0] stage3_reg; // Third stage
	logic [WIDTH-1:0] level_reg; // Accepted level

	// Shift the pad levels through three flops
	always_ff @(posedge clk) begin
		if (reset) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
		end else begin
			stage1_reg <= port.raw;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// ==========================================================
	// Agreement filter
	// A change is accepted only once stages two and three agree,
	// so a one-cycle glitch past the first flop never passes.
	always_ff @(posedge clk) begin
		if (reset) begin
			level_reg <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_reg[i] <= stage3_reg[i];
				end
			end
		end
	end

	assign port.level = level_reg;

endmodule

// [port_a_mux_props.sv]
// Checker for the port A pin function multiplexer
`timescale 1ns/1ps
module port_a_mux_props
	import port_a_mux_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset, // Sync reset
	input wire logic [7:0] regAddr, // Address
	input wire logic [31:0] regWrData, // Write data
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	input wire logic [31:0] regRdData, // Read data
	input wire logic [NUM_PINS-1:0] pinOut, // Pad drive
	input wire logic [NUM_PINS-1:0] pinOe, // Pad enables
	input wire logic [NUM_PINS-1:0] gpioOut, // GPIO drive
	input wire logic [3:0] pwmOutA, // PWM outputs A
	input wire logic comparator1Out, // Comparator 1
	input wire logic serialTransmit, // Serial out
	input wire logic clockOutputPin, // Clock out
	input wire logic i2cClockPullLow, // I2C clock pull
	input wire logic [NUM_INPUTS-1:0] periphInput // Routed inputs
);
	// ==========================================================
	// Shadow of the select registers
	logic [31:0] lowReg; // Select low copy
	logic [31:0] highReg; // Select high copy
	logic [1:0] ageReg; // Edges since reset, saturating
	logic live; // Pad outputs settled after reset
	logic [1:0] rxSrc; // Pins feeding serial receive

	// Copy writes; reserved bits are dropped as in the design
	always_ff @(posedge clk) begin
		if (reset) begin
			lowReg <= SEL_LOW_RESET;
			highReg <= SEL_HIGH_RESET;
		end else if (regWrite && regAddr == SEL_LOW_ADDR) begin
			lowReg <= regWrData & SEL_LOW_WMASK;
		end else if (regWrite && regAddr == SEL_HIGH_ADDR) begin
			highReg <= regWrData & SEL_HIGH_WMASK;
		end
	end

	// Pads follow from the 1st edge after reset; checks wait three
	always_ff @(posedge clk) begin
		if (reset) begin
			ageReg <= 2'h0;
		end else if (ageReg != 2'h3) begin
			ageReg <= ageReg + 2'h1;
		end
	end

	assign live = (ageReg == 2'h3);
	assign rxSrc = {1'b0, lowReg[15:14] == SEL_PERIPH2}
		+ {1'b0, highReg[7:6] == SEL_PERIPH2}
		+ {1'b0, highReg[25:24] == SEL_PERIPH1};

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	chk_read_back: assert property (regRead && regAddr == SEL_LOW_ADDR
		|=> regRdData == $past(lowReg)) else $error("select read wrong");
	chk_reset_inputs: assert property ($fell(reset)
		|-> periphInput == INPUT_DEFAULTS) else $error("input reset wrong");
	chk_gpio_pass: assert property (live && lowReg[1:0] == SEL_GPIO
		|=> pinOut[0] == $past(gpioOut[0])) else $error("gpio drive lost");
	chk_pin6_pwm: assert property (live && lowReg[13:12] == SEL_PERIPH1
		|=> pinOut[6] == $past(pwmOutA[3]) && pinOe[6])
		else $error("pin 6 pwm wrong");
	chk_pin1_comp: assert property (live && lowReg[3:2] == SEL_PERIPH3
		|=> pinOut[1] == $past(comparator1Out) && pinOe[1])
		else $error("pin 1 comparator wrong");
	chk_pin18_clock: assert property (live && highReg[5:4] == SEL_PERIPH3
		|=> pinOut[18] == $past(clockOutputPin) && pinOe[18])
		else $error("pin 18 clock wrong");
	chk_pin29_i2c: assert property (live && highReg[27:26] == SEL_PERIPH2
		|=> !pinOut[29] && pinOe[29] == $past(i2cClockPullLow))
		else $error("pin 29 i2c wrong");
	chk_pin12_serial: assert property (live && lowReg[25:24] == SEL_PERIPH2
		|=> pinOut[12] == $past(serialTransmit) && pinOe[12])
		else $error("pin 12 serial wrong");
	chk_sync_default: assert property (live && lowReg[13:12] != SEL_PERIPH2
		|=> !periphInput[IN_SYNC]) else $error("sync default wrong");
	chk_rx_default: assert property (live && rxSrc != 2'h1
		|=> periphInput[IN_SERIAL_RX]) else $error("rx default wrong");

	// Main scenarios reached
	cover property (regRead && regAddr == SEL_LOW_ADDR);
	cover property (live && lowReg[13:12] == SEL_PERIPH1);
	cover property (live && rxSrc == 2'h2);
	cover property (live && highReg[27:26] == SEL_PERIPH2);
endmodule

bind port_a_pin_function_mux port_a_mux_props i_port_a_mux_props (.clk,
	.reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pinOut,
	.pinOe, .gpioOut, .pwmOutA, .comparator1Out, .serialTransmit,
	.clockOutputPin, .i2cClockPullLow, .periphInput);

// [pad_model.sv]
// Pad and board model on the far side of the multiplexer
`timescale 1ns/1ps
module pad_model
	import port_a_mux_pkg::*;
(
	input wire logic [NUM_PINS-1:0] pinOut, // Device drive
	input wire logic [NUM_PINS-1:0] pinOe, // Device enables
	input wire logic [NUM_PINS-1:0] boardLevel, // Pull when released
	output logic [NUM_PINS-1:0] pinIn // Level seen at pads
);
	// Driven pads show the device level, released ones the board pull
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pinIn[i] = pinOe[i] ? pinOut[i] : boardLevel[i];
		end
	end
endmodule

// [test_port_a_pin_function_mux.sv]
// Testbench for the port A pin function multiplexer
`timescale 1ns/1ps
module test_port_a_pin_function_mux
	import port_a_mux_pkg::*;
;
	// ==========================================================
	// Stimulus and observed signals
	logic clk = 1'b0; // 50 MHz clock
	logic reset = 1'b1; // Held 8 cycles
	logic [7:0] regAddr = 8'h00; // Bus address
	logic [31:0] regWrData = 32'h0; // Bus write data
	logic regWrite = 1'b0; // Write strobe
	logic regRead = 1'b0; // Read strobe
	logic [31:0] regRdData; // Read data
	logic [31:0] pinIn, pinOut, pinOe, gpioIn; // Pad side
	logic [31:0] gpioOut = 32'h5a5a_c33c; // GPIO drive
	logic [31:0] gpioOe = 32'hf0f0_0ff0; // GPIO enables
	logic [31:0] board = 32'h0; // Board pulls
	logic [17:0] drv = 18'h1_5a3c; // Peripheral drives
	logic [4:0] drvOe = 5'h1f; // Peripheral enables
	logic [1:0] pull = 2'h0; // I2C pull-low requests
	logic [11:0] periphInput; // Routed inputs
	logic [31:0] lo = 32'h0, hi = 32'h0; // Select copies
	int n_mismatch = 0, tests_run = 0, cycles = 0; // Counters
	// Output cases: pin, code, drive bit
	int oc[20][3] = '{'{0,1,0}, '{1,1,4}, '{1,3,8}, '{2,1,1}, '{3,1,5},
		'{3,3,9}, '{4,1,2}, '{5,1,6}, '{5,3,11}, '{6,1,3}, '{6,3,10},
		'{7,1,7}, '{12,2,12}, '{18,1,14}, '{18,2,12}, '{18,3,13},
		'{19,1,15}, '{16,1,16}, '{17,1,17}, '{29,1,12}};
	// Input cases: pin, code, input position
	int ic[17][3] = '{'{12,1,0}, '{16,3,1}, '{17,3,2}, '{6,2,3},
		'{5,3,4}, '{19,3,4}, '{18,1,5}, '{19,1,6}, '{16,1,7}, '{17,1,8},
		'{7,2,9}, '{19,2,9}, '{28,1,9}, '{28,2,10}, '{29,2,11},
		'{28,3,1}, '{29,3,2}};

	always #10 clk = ~clk;

	port_a_pin_function_mux i_port_a_pin_function_mux (.clk, .reset,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pinIn,
		.pinOut, .pinOe, .gpioOut, .gpioOe, .gpioIn, .pwmOutA(drv[3:0]),
		.pwmOutB(drv[7:4]), .comparator1Out(drv[8]),
		.comparator2Out(drv[9]), .pwmSyncOutput(drv[10]),
		.capture1Out(drv[11]), .capture1Oe(drvOe[0]),
		.serialTransmit(drv[12]), .clockOutputPin(drv[13]),
		.spiClockOut(drv[14]), .spiClockOe(drvOe[1]),
		.spiSlaveEnableOut(drv[15]), .spiSlaveEnableOe(drvOe[2]),
		.spiDataToSlaveOut(drv[16]), .spiDataToSlaveOe(drvOe[3]),
		.spiDataFromSlaveOut(drv[17]), .spiDataFromSlaveOe(drvOe[4]),
		.i2cDataPullLow(pull[0]), .i2cClockPullLow(pull[1]), .periphInput);

	pad_model i_pad_model (.pinOut, .pinOe, .boardLevel(board), .pinIn);

	// ==========================================================
	// Bus tasks and comparisons
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		cmp32("read data", e, regRdData);
	endtask

	// This task sets one pin field to any code, then waits two falling edges
	task automatic sel(input int p, input logic [1:0] c);
		if (p < 16) begin
			lo[2*p +: 2] = c;
			wr(SEL_LOW_ADDR, lo);
		end else begin
			hi[2*(p-16) +: 2] = c;
			wr(SEL_HIGH_ADDR, hi);
		end
		repeat (2) @(negedge clk);
	endtask

	task automatic cmp1(input string s, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic cmp32(input string s, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (6) @(negedge clk);
		cmp32("pad drive", gpioOut, pinOut);
		cmp32("pad enable", gpioOe, pinOe);
		cmp32("inputs", 32'hfb7, {20'h0, periphInput});
		rd(SEL_LOW_ADDR, 32'h0);
		rd(SEL_HIGH_ADDR, 32'h0);
		rd(DEFAULTED_ADDR, 32'hfff);
		rd(8'h10, 32'h0);
		wr(SEL_HIGH_ADDR, 32'hf0ff_ff00);
		rd(SEL_HIGH_ADDR, 32'h0);
		wr(SEL_LOW_ADDR, 32'h0200_7ddd);
		rd(SEL_LOW_ADDR, 32'h0200_7ddd);
		wr(SEL_LOW_ADDR, 32'h0);
		// Outputs, once with each polarity of the drives
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			drv <= ~drv;
			// Toggle general I/O too, so a stuck pad path shows
			gpioOut <= ~gpioOut;
			for (int i = 0; i < 20; i++) begin
				sel(oc[i][0], 2'(oc[i][1]));
				cmp1("drive", drv[oc[i][2]], pinOut[oc[i][0]]);
				cmp1("enable", 1'b1, pinOe[oc[i][0]]);
				sel(oc[i][0], SEL_GPIO);
			end
			cmp32("pad drive", gpioOut, pinOut);
		end
		// Open-drain I2C pins
		@(posedge clk);
		pull <= 2'h3;
		sel(28, SEL_PERIPH2);
		sel(29, SEL_PERIPH2);
		cmp32("i2c pads", 32'hc, {28'h0, pinOe[29:28], pinOut[29:28]});
		// Inputs, pads released, board high then low
		@(posedge clk);
		pull <= 2'h0;
		gpioOe <= 32'h0;
		drvOe <= 5'h0;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			board <= k ? 32'h0 : 32'hffff_ffff;
			repeat (8) @(posedge clk);
			rd(PIN_LEVEL_ADDR, board);
			cmp32("pin levels", board, gpioIn);
			for (int i = 0; i < 17; i++) begin
				sel(ic[i][0], 2'(ic[i][1]));
				cmp1("input", board[ic[i][0]], periphInput[ic[i][2]]);
				sel(ic[i][0], SEL_GPIO);
			end
		end
		// Two sources for serial receive: default high, board low
		sel(7, SEL_PERIPH2);
		sel(19, SEL_PERIPH2);
		cmp1("rx default", 1'b1, periphInput[IN_SERIAL_RX]);
		rd(DEFAULTED_ADDR, 32'hfff);
		tally_and_finish();
	end
endmodule
